// >>> inc/usr_pkg.sv
package usr_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_SERIAL_STATUS = 16'h4120;
   localparam logic [15:0] IDX_SERIAL_TRANSMIT_BYTE = 16'h4121;
   localparam logic [15:0] IDX_INFRARED_MODE_CONTROL = 16'h4123;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h4124;
   localparam logic [15:0] IDX_IRQ_CLEAR = 16'h4125;
   localparam logic [15:0] IDX_IRQ_ENABLE = 16'h4126;

   // ----------------------------------------------------------------
   // serial_status field positions
   // ----------------------------------------------------------------
   localparam int POS_FRAMING_ERR = 6;
   localparam int POS_PARITY_ERR = 5;
   localparam int POS_OVERRUN_ERR = 4;
   localparam int POS_SECOND_BYTE = 3;
   localparam int POS_TX_BUSY = 2;
   localparam int POS_RX_READY = 1;
   localparam int POS_TX_BUFFER_EMPTY = 0;

   // infrared_mode_control field position
   localparam int POS_INFRARED_MODE_SEL = 0;

   // ----------------------------------------------------------------
   // interrupt event layout
   // ----------------------------------------------------------------
   localparam int IRQ_W = 5;
   localparam int IRQ_TX_EMPTY = 0;
   localparam int IRQ_RX_READY = 1;
   localparam int IRQ_FRAMING = 2;
   localparam int IRQ_PARITY = 3;
   localparam int IRQ_OVERRUN = 4;

   // ----------------------------------------------------------------
   // reset values and data limits
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_TRANSMIT_BYTE = 8'h00;
   localparam logic RST_TX_BUFFER_EMPTY = 1'b1;
   localparam logic RST_INFRARED_MODE_SEL = 1'b0;
   localparam logic [IRQ_W-1:0] RST_IRQ_ENABLE = 5'h00;
   localparam logic [7:0] SEVEN_BIT_MASK = 8'h7f;
   localparam logic [1:0] RX_DEPTH = 2'h2;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic framing_err;
      logic parity_err;
      logic overrun_err;
      logic byte_in;
      logic byte_taken;
   } usr_rx_evt_type;

   typedef struct packed {
      logic start;
      logic [7:0] data;
   } usr_tx_req_type;

endpackage : usr_pkg

// >>> src/usr_sticky.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// sticky flags, set beats clear in the same cycle
// ------------------------------------------------------------------
module usr_sticky #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // events
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   // flags
   output logic [W-1:0] flag
);

   typedef struct packed {
      logic [W-1:0] flag;
   } usr_sticky_state_type;

   usr_sticky_state_type state;
   usr_sticky_state_type next_state;

   always_comb begin
      next_state = state;
      // a clear never loses an event of the same cycle
      next_state.flag = (state.flag & ~clr) | set;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign flag = state.flag;

endmodule : usr_sticky

`default_nettype wire

// >>> src/usr_regs.sv
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module usr_regs #(
   parameter int ADDR_W = 18
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // receiver events, same clock
   input wire usr_pkg::usr_rx_evt_type rx_evt,
   // frame format, same clock
   input wire logic seven_bit_frame,
   // transmit shifter handshake, same clock
   input wire logic tx_shift_ready,
   input wire logic tx_shift_done,
   output usr_pkg::usr_tx_req_type tx_req,
   // infrared modulator control
   output logic infrared_mode_sel,
   // interrupt
   output logic irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic waitreq;
      logic [31:0] readdata;
      logic ir_mode;
      logic [7:0] tx_byte;
      logic tx_empty;
      logic tx_busy;
      logic tx_start;
      logic [7:0] tx_data;
      logic [1:0] rx_count;
      logic [usr_pkg::IRQ_W-1:0] irq_enable;
      logic irq;
   } usr_regs_state_type;

   usr_regs_state_type state;
   usr_regs_state_type next_state;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic [15:0] word_index;
   logic access_now;
   logic wr_now;
   logic wr_lane0;
   logic sel_status;
   logic sel_tx_byte;
   logic sel_ir;
   logic sel_irq_status;
   logic sel_irq_clear;
   logic sel_irq_enable;

   assign word_index = 16'(avs_address[ADDR_W-1:2]);
   // the access completes in the cycle where waitrequest is low
   assign access_now = (avs_read | avs_write) & ~state.waitreq;
   assign wr_now = avs_write & ~state.waitreq;
   assign wr_lane0 = wr_now & avs_byteenable[0];
   assign sel_status = (word_index == usr_pkg::IDX_SERIAL_STATUS);
   assign sel_tx_byte = (word_index == usr_pkg::IDX_SERIAL_TRANSMIT_BYTE);
   assign sel_ir = (word_index == usr_pkg::IDX_INFRARED_MODE_CONTROL);
   assign sel_irq_status = (word_index == usr_pkg::IDX_IRQ_STATUS);
   assign sel_irq_clear = (word_index == usr_pkg::IDX_IRQ_CLEAR);
   assign sel_irq_enable = (word_index == usr_pkg::IDX_IRQ_ENABLE);

   // ----------------------------------------------------------------
   // receive occupancy and error flags
   // ----------------------------------------------------------------
   logic rx_full_push;
   logic [2:0] err_set;
   logic [2:0] err_clr;
   logic [2:0] err_flag;

   // a byte arriving with both slots held and none leaving is lost
   assign rx_full_push = rx_evt.byte_in & ~rx_evt.byte_taken & (state.rx_count == usr_pkg::RX_DEPTH);

   assign err_set[2] = rx_evt.framing_err;
   assign err_set[1] = rx_evt.parity_err;
   assign err_set[0] = rx_evt.overrun_err | rx_full_push;

   // writing a one to an error bit clears it
   assign err_clr[2] = wr_lane0 & sel_status & avs_writedata[usr_pkg::POS_FRAMING_ERR];
   assign err_clr[1] = wr_lane0 & sel_status & avs_writedata[usr_pkg::POS_PARITY_ERR];
   assign err_clr[0] = wr_lane0 & sel_status & avs_writedata[usr_pkg::POS_OVERRUN_ERR];

   usr_sticky #(
      .W(3)
   ) u_err (
      .clk_sys(clk_sys),
      .rst(rst),
      .set(err_set),
      .clr(err_clr),
      .flag(err_flag)
   );

   // ----------------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------------
   logic [usr_pkg::IRQ_W-1:0] irq_set;
   logic [usr_pkg::IRQ_W-1:0] irq_clr;
   logic [usr_pkg::IRQ_W-1:0] irq_flag;

   always_comb begin
      irq_set = '0;
      irq_set[usr_pkg::IRQ_TX_EMPTY] = state.tx_start;
      irq_set[usr_pkg::IRQ_RX_READY] = rx_evt.byte_in;
      irq_set[usr_pkg::IRQ_FRAMING] = err_set[2];
      irq_set[usr_pkg::IRQ_PARITY] = err_set[1];
      irq_set[usr_pkg::IRQ_OVERRUN] = err_set[0];
   end

   assign irq_clr = (wr_lane0 & sel_irq_clear) ? avs_writedata[usr_pkg::IRQ_W-1:0] : '0;

   usr_sticky #(
      .W(usr_pkg::IRQ_W)
   ) u_irq (
      .clk_sys(clk_sys),
      .rst(rst),
      .set(irq_set),
      .clr(irq_clr),
      .flag(irq_flag)
   );

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   logic [7:0] status_byte;
   logic [31:0] read_word;

   always_comb begin
      status_byte = 8'h00;
      status_byte[usr_pkg::POS_FRAMING_ERR] = err_flag[2];
      status_byte[usr_pkg::POS_PARITY_ERR] = err_flag[1];
      status_byte[usr_pkg::POS_OVERRUN_ERR] = err_flag[0];
      status_byte[usr_pkg::POS_SECOND_BYTE] = (state.rx_count == usr_pkg::RX_DEPTH);
      status_byte[usr_pkg::POS_TX_BUSY] = state.tx_busy;
      status_byte[usr_pkg::POS_RX_READY] = (state.rx_count != 2'h0);
      status_byte[usr_pkg::POS_TX_BUFFER_EMPTY] = state.tx_empty;
   end

   always_comb begin
      read_word = 32'h0000_0000;
      if (sel_status) begin
         read_word[7:0] = status_byte;
      end else if (sel_tx_byte) begin
         read_word[7:0] = state.tx_byte;
      end else if (sel_ir) begin
         read_word[usr_pkg::POS_INFRARED_MODE_SEL] = state.ir_mode;
      end else if (sel_irq_status) begin
         read_word[usr_pkg::IRQ_W-1:0] = irq_flag;
      end else if (sel_irq_enable) begin
         read_word[usr_pkg::IRQ_W-1:0] = state.irq_enable;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic load_tx;
   logic start_now;

   assign load_tx = wr_lane0 & sel_tx_byte;
   // one start per byte: the pulse itself blocks a second one
   assign start_now = ~state.tx_empty & tx_shift_ready & ~state.tx_start;

   always_comb begin
      next_state = state;

      // one wait cycle, then the answer; readdata is ready at that edge
      next_state.waitreq = ~((avs_read | avs_write) & state.waitreq);
      if ((avs_read | avs_write) & state.waitreq) begin
         next_state.readdata = read_word;
      end

      if (wr_lane0 & sel_ir) begin
         next_state.ir_mode = avs_writedata[usr_pkg::POS_INFRARED_MODE_SEL];
      end
      if (wr_lane0 & sel_irq_enable) begin
         next_state.irq_enable = avs_writedata[usr_pkg::IRQ_W-1:0];
      end

      // transmit buffer and shifter hand-off
      next_state.tx_start = start_now;
      if (start_now) begin
         // seven-bit frames carry only the low seven bits
         next_state.tx_data = seven_bit_frame ? (state.tx_byte & usr_pkg::SEVEN_BIT_MASK) : state.tx_byte;
         next_state.tx_empty = 1'b1;
      end
      if (load_tx) begin
         // a write into a full buffer replaces the waiting byte
         next_state.tx_byte = avs_writedata[7:0];
         next_state.tx_empty = 1'b0;
      end
      if (start_now) begin
         next_state.tx_busy = 1'b1;
      end else if (tx_shift_done & state.tx_empty & ~state.tx_start) begin
         next_state.tx_busy = 1'b0;
      end

      // receive occupancy, capped at two bytes
      if (rx_evt.byte_in & ~rx_evt.byte_taken & (state.rx_count != usr_pkg::RX_DEPTH)) begin
         next_state.rx_count = state.rx_count + 2'h1;
      end else if (rx_evt.byte_taken & ~rx_evt.byte_in & (state.rx_count != 2'h0)) begin
         next_state.rx_count = state.rx_count - 2'h1;
      end

      next_state.irq = |(irq_flag & state.irq_enable);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state.waitreq <= 1'b1;
         state.readdata <= 32'h0000_0000;
         state.ir_mode <= usr_pkg::RST_INFRARED_MODE_SEL;
         state.tx_byte <= usr_pkg::RST_TRANSMIT_BYTE;
         state.tx_empty <= usr_pkg::RST_TX_BUFFER_EMPTY;
         state.tx_busy <= 1'b0;
         state.tx_start <= 1'b0;
         state.tx_data <= usr_pkg::RST_TRANSMIT_BYTE;
         state.rx_count <= 2'h0;
         state.irq_enable <= usr_pkg::RST_IRQ_ENABLE;
         state.irq <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign avs_readdata = state.readdata;
   assign avs_waitrequest = state.waitreq;
   assign tx_req.start = state.tx_start;
   assign tx_req.data = state.tx_data;
   assign infrared_mode_sel = state.ir_mode;
   assign irq = state.irq;

endmodule : usr_regs

`default_nettype wire

// >>> sim/usr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module usr_regs_asserts #(
   parameter int ADDR_W = 18
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register bus
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // transmit side
   input wire logic seven_bit_frame,
   input wire logic tx_shift_ready,
   input wire usr_pkg::usr_tx_req_type tx_req,
   input wire logic infrared_mode_sel
);
   logic done;
   logic [15:0] idx;
   logic ir_wr;
   logic st_rd;
   logic ir_rd;
   assign done = !avs_waitrequest;
   assign idx = avs_address[ADDR_W-1:2];
   assign ir_wr = avs_write && done && avs_byteenable[0] && idx == usr_pkg::IDX_INFRARED_MODE_CONTROL;
   assign st_rd = avs_read && done && idx == usr_pkg::IDX_SERIAL_STATUS;
   assign ir_rd = avs_read && done && idx == usr_pkg::IDX_INFRARED_MODE_CONTROL;

   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> done)
      else $error("bus request not answered after one wait cycle");
   ir_write_a: assert property (ir_wr |=> infrared_mode_sel == $past(avs_writedata[0]))
      else $error("infrared select does not follow write");
   ir_hold_a: assert property (!ir_wr |=> $stable(infrared_mode_sel))
      else $error("infrared select changed without write");
   status_rsv_a: assert property (st_rd |-> avs_readdata[31:7] == 25'h0)
      else $error("reserved status bits not zero");
   ir_rsv_a: assert property (ir_rd |-> avs_readdata[31:1] == 31'h0)
      else $error("reserved infrared bits not zero");
   start_pulse_a: assert property (tx_req.start |=> !tx_req.start)
      else $error("start longer than one cycle");
   start_ready_a: assert property (tx_req.start |-> $past(tx_shift_ready))
      else $error("start while shifter not ready");
   seven_mask_a: assert property (tx_req.start && $past(seven_bit_frame) |-> !tx_req.data[7])
      else $error("seven bit byte not masked");
   data_hold_a: assert property (!tx_req.start |-> $stable(tx_req.data))
      else $error("transmit data changed without start");
endmodule : usr_regs_asserts

bind usr_regs usr_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk_sys(clk_sys), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .seven_bit_frame(seven_bit_frame),
   .tx_shift_ready(tx_shift_ready), .tx_req(tx_req), .infrared_mode_sel(infrared_mode_sel));

`default_nettype wire

// >>> sim/tb_uart_status_and_tx_data_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_uart_status_and_tx_data_regs;
   localparam logic [15:0] A_ST = usr_pkg::IDX_SERIAL_STATUS;
   localparam logic [15:0] A_TX = usr_pkg::IDX_SERIAL_TRANSMIT_BYTE;
   localparam logic [15:0] A_IR = usr_pkg::IDX_INFRARED_MODE_CONTROL;
   localparam logic [15:0] A_IS = usr_pkg::IDX_IRQ_STATUS;
   localparam logic [15:0] A_IC = usr_pkg::IDX_IRQ_CLEAR;
   localparam logic [15:0] A_EN = usr_pkg::IDX_IRQ_ENABLE;
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   logic [17:0] avs_address = 18'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   usr_pkg::usr_rx_evt_type rx_evt = '0;
   logic seven_bit_frame = 1'h0;
   logic tx_shift_ready = 1'h0;
   logic tx_shift_done = 1'h0;
   usr_pkg::usr_tx_req_type tx_req;
   logic infrared_mode_sel;
   logic irq;
   int err_total = 0;
   int checks = 0;
   logic [31:0] rd;

   usr_regs #(.ADDR_W(18)) i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rx_evt(rx_evt), .seven_bit_frame(seven_bit_frame), .tx_shift_ready(tx_shift_ready),
      .tx_shift_done(tx_shift_done), .tx_req(tx_req), .infrared_mode_sel(infrared_mode_sel), .irq(irq));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task finish_test;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // request held until waitrequest is sampled low, released only after that edge
   task bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk_sys);
      avs_address <= {idx, 2'h0};
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      if (avs_waitrequest !== 1'h0) begin
         err_total++;
         $display("mismatch at %0t: bus timeout", $time);
         finish_test();
      end
   endtask : bus

   task rd_chk(input logic [15:0] idx, input logic [31:0] exp, input string what);
      bus(1'h0, idx, 8'h0);
      chk(rd, exp, what);
   endtask : rd_chk

   task evt(input logic [4:0] v);
      @(posedge clk_sys);
      rx_evt <= usr_pkg::usr_rx_evt_type'(v);
      @(posedge clk_sys);
      rx_evt <= '0;
   endtask : evt

   // shifter drops ready at the start edge so it never takes a second byte
   task wait_start(input logic [7:0] exp);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (tx_req.start !== 1'h1 && n < 50);
      tx_shift_ready <= 1'h0;
      chk({31'h0, tx_req.start}, 32'h1, "start pulse");
      chk({24'h0, tx_req.data}, {24'h0, exp}, "transmit data");
      if (tx_req.start !== 1'h1) finish_test();
   endtask : wait_start

   task done_pulse;
      @(posedge clk_sys);
      tx_shift_done <= 1'h1;
      @(posedge clk_sys);
      tx_shift_done <= 1'h0;
   endtask : done_pulse

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset;
      rd_chk(A_ST, 32'h01, "status reset");
      rd_chk(A_TX, 32'h00, "tx byte reset");
      rd_chk(A_IR, 32'h00, "infrared reset");
      rd_chk(A_EN, 32'h00, "irq enable reset");
      chk({31'h0, irq}, 32'h0, "irq reset");
      $display("test reset done");
   endtask : t_reset

   task t_infrared;
      bus(1'h1, A_IR, 8'hff);
      rd_chk(A_IR, 32'h01, "infrared set");
      chk({31'h0, infrared_mode_sel}, 32'h1, "infrared pin");
      avs_byteenable <= 4'h0;
      bus(1'h1, A_IR, 8'h00);
      avs_byteenable <= 4'hf;
      rd_chk(A_IR, 32'h01, "masked write ignored");
      bus(1'h1, A_IR, 8'h00);
      // the write lands at the completion edge, and the pin follows the register from that same edge
      @(posedge clk_sys);
      chk({31'h0, infrared_mode_sel}, 32'h0, "infrared off");
      bus(1'h1, 16'h4127, 8'hff);
      rd_chk(16'h4127, 32'h0, "unmapped");
      $display("test infrared done");
   endtask : t_infrared

   task t_errors;
      bus(1'h1, A_EN, 8'h04);
      evt(5'h08);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0, "irq masked");
      evt(5'h10);
      evt(5'h04);
      rd_chk(A_ST, 32'h71, "errors set");
      chk({31'h0, irq}, 32'h1, "irq raised");
      bus(1'h1, A_ST, 8'h20);
      rd_chk(A_ST, 32'h51, "parity cleared");
      bus(1'h1, A_ST, 8'h50);
      rd_chk(A_ST, 32'h01, "errors cleared");
      rd_chk(A_IS, 32'h1c, "irq status");
      bus(1'h1, A_IC, 8'h1f);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      rd_chk(A_IS, 32'h00, "irq status cleared");
      bus(1'h1, A_EN, 8'h00);
      $display("test errors done");
   endtask : t_errors

   task t_receive;
      evt(5'h02);
      rd_chk(A_ST, 32'h03, "one byte");
      evt(5'h02);
      rd_chk(A_ST, 32'h0b, "two bytes");
      evt(5'h02);
      rd_chk(A_ST, 32'h1b, "third byte overrun");
      evt(5'h01);
      rd_chk(A_ST, 32'h13, "one taken");
      evt(5'h01);
      rd_chk(A_ST, 32'h11, "all taken");
      bus(1'h1, A_ST, 8'h10);
      rd_chk(A_ST, 32'h01, "overrun cleared");
      $display("test receive done");
   endtask : t_receive

   task t_transmit;
      bus(1'h1, A_TX, 8'ha5);
      rd_chk(A_ST, 32'h00, "buffer full");
      rd_chk(A_TX, 32'ha5, "tx byte readback");
      tx_shift_ready <= 1'h1;
      wait_start(8'ha5);
      rd_chk(A_ST, 32'h05, "sending");
      // start, received bytes and the internal overrun left their sticky bits
      rd_chk(A_IS, 32'h13, "irq status tx rx overrun");
      bus(1'h1, A_IC, 8'h1f);
      rd_chk(A_IS, 32'h00, "irq status cleared again");
      done_pulse();
      rd_chk(A_ST, 32'h01, "idle");
      seven_bit_frame <= 1'h1;
      bus(1'h1, A_TX, 8'hff);
      tx_shift_ready <= 1'h1;
      wait_start(8'h7f);
      done_pulse();
      seven_bit_frame <= 1'h0;
      $display("test transmit done");
   endtask : t_transmit

   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'h0;
      t_reset();
      t_infrared();
      t_errors();
      t_receive();
      t_transmit();
      finish_test();
   end
endmodule : tb_uart_status_and_tx_data_regs

`default_nettype wire
